// ---- rtl/ext_arith_pkg.sv ----
// constants, types and register map for the extended arithmetic unit
package ext_arith_pkg;
  localparam int WORD_W = 12;
  localparam int SC_W = 5;
  localparam int IR_W = 3;
  // timing
  localparam int CLOCK_NS = 10;
  localparam int AT_PERIOD_NS = 450;
  localparam int AT_CYCLES = AT_PERIOD_NS / CLOCK_NS;
  localparam int LOAD_NS = 100;
  localparam int LOAD_CYCLES = (LOAD_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam logic [5:0] AT_LAST = 6'(AT_CYCLES - 1);
  localparam logic [3:0] LOAD_COUNT = 4'(LOAD_CYCLES);
  // buffer bit positions (bit 00 is the most significant)
  localparam int MB_OWN_A = 3;
  localparam int MB_OWN_B = 11;
  localparam int MB_IR_LO = 8;
  localparam int MB_IR_HI = 10;
  localparam int MB_SCL_ZERO = 9;
  localparam int MB_SCL_ONE = 10;
  localparam int MB_SC_LO = 7;
  localparam int MB_SC_HI = 11;
  // instruction_reg codes, bits 08..10
  localparam logic [IR_W-1:0] IR_NORMALIZE = 3'h4;
  localparam logic [IR_W-1:0] IR_STEP_LOAD = 3'h1;
  localparam logic [IR_W-1:0] IR_MULTIPLY = 3'h2;
  localparam logic [IR_W-1:0] IR_DIVIDE = 3'h3;
  localparam logic [IR_W-1:0] IR_RESET = 3'h0;
  localparam logic [WORD_W-1:0] WORD_ZERO = 12'h000;
  // register map
  localparam logic [7:0] ADR_PRIMARY = 8'h00;
  localparam logic [7:0] ADR_QUOTIENT = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam int STAT_IR_LO = 5;
  localparam int STAT_BUSY = 8;
  localparam int STAT_SCALED = 9;
  localparam int STAT_PAUSE = 10;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
  // processor side carriers
  typedef struct packed {
    logic fetch;
    logic execute;
    logic operate;
    logic tp3;
    logic tp4;
    logic [0:WORD_W-1] mb;
  } cpu_in_t;
  typedef struct packed {
    logic arith_begin;
    logic arith_start_n;
    logic pause_set;
    logic goto_execute;
    logic end_pulse;
    logic already_scaled_n;
    logic load_strobe;
  } cpu_out_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } arith_state_t;
endpackage

// ---- rtl/ext_arith_unit.sv ----
// normalize and step-count load path of the extended arithmetic unit, with wishbone registers
`timescale 1ns/10ps
module ext_arith_unit (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // processor side
  input wire ext_arith_pkg::cpu_in_t i_cpu,
  output ext_arith_pkg::cpu_out_t o_cpu
);
  ext_arith_pkg::arith_state_t state_q;
  logic [0:ext_arith_pkg::WORD_W-1] primary_q;
  logic [0:ext_arith_pkg::WORD_W-1] quotient_q;
  logic [0:ext_arith_pkg::WORD_W-1] primary_shift;
  logic [0:ext_arith_pkg::WORD_W-1] quotient_shift;
  logic [ext_arith_pkg::IR_W-1:0] instr_q;
  logic [0:ext_arith_pkg::SC_W-1] shift_count;
  logic [0:ext_arith_pkg::SC_W-1] mb_count_src;
  logic [5:0] at_div_q;
  logic at_pulse_q;
  logic [3:0] strobe_cnt_q;
  logic [3:0] strobe_len_q;
  ext_arith_pkg::cpu_out_t cpu_q;
  logic scaled;
  logic running;
  logic own_fetch;
  logic nmi_fire;
  logic nmi_start;
  logic scl_go;
  logic arith_begin_now;
  logic mul_div_pending;
  logic scl_fire;
  logic shift_fire;
  logic end_fire;
  logic bus_req;
  logic bus_write;
  logic [0:ext_arith_pkg::WORD_W-1] wr_word;
  logic [5:0] shifts_seen_q;

  // own-instruction decode, shared by the fetch paths
  function automatic logic arith_instr_decode(input ext_arith_pkg::cpu_in_t c);
    arith_instr_decode = c.fetch & c.operate & c.mb[ext_arith_pkg::MB_OWN_A] & c.mb[ext_arith_pkg::MB_OWN_B];
  endfunction

  // byte-lane merge of a 12-bit register from a 32-bit write
  function automatic logic [0:ext_arith_pkg::WORD_W-1] merge_word(input logic [0:ext_arith_pkg::WORD_W-1] old,
                                                                  input logic [31:0] dat,
                                                                  input logic [3:0] sel);
    logic [11:0] v;
    v = old;
    if (sel[0]) begin
      v[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      v[11:8] = dat[11:8];
    end
    merge_word = v;
  endfunction

  // normalized test tree, evaluated every cycle
  assign scaled = (primary_q[0] ^ primary_q[1]) ||
                  (primary_q[2:ext_arith_pkg::WORD_W-1] == 10'h000 && quotient_q == ext_arith_pkg::WORD_ZERO);

  // one long left shift with zero fill
  assign primary_shift = {primary_q[1:ext_arith_pkg::WORD_W-1], quotient_q[0]};
  assign quotient_shift = {quotient_q[1:ext_arith_pkg::WORD_W-1], 1'b0};

  // decode of fetch and execute events
  assign running = (state_q == ext_arith_pkg::ST_RUN);
  assign own_fetch = (state_q == ext_arith_pkg::ST_IDLE) && arith_instr_decode(i_cpu) && i_cpu.tp3;
  assign nmi_fire = own_fetch &&
                    (i_cpu.mb[ext_arith_pkg::MB_IR_LO:ext_arith_pkg::MB_IR_HI] == ext_arith_pkg::IR_NORMALIZE);
  assign nmi_start = nmi_fire && !scaled;
  assign scl_go = own_fetch && !i_cpu.mb[ext_arith_pkg::MB_SCL_ZERO] && i_cpu.mb[ext_arith_pkg::MB_SCL_ONE];
  assign arith_begin_now = i_cpu.execute && i_cpu.operate;
  assign mul_div_pending = (instr_q == ext_arith_pkg::IR_MULTIPLY) || (instr_q == ext_arith_pkg::IR_DIVIDE);
  assign scl_fire = arith_begin_now && !running && !mul_div_pending && i_cpu.tp3;
  assign shift_fire = running && at_pulse_q && !scaled;
  assign end_fire = running && at_pulse_q && scaled;

  // complemented word tail for the count load
  assign mb_count_src = ~i_cpu.mb[ext_arith_pkg::MB_SC_LO:ext_arith_pkg::MB_SC_HI];

  // bus decode
  assign bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign bus_write = bus_req && i_wb_we && !running;
  assign wr_word = merge_word((i_wb_adr == ext_arith_pkg::ADR_PRIMARY) ? primary_q : quotient_q, i_wb_dat, i_wb_sel);

  // shift_count register
  step_counter u_count (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_clear(nmi_fire),
    .i_increment(shift_fire),
    .i_load(scl_fire),
    .i_load_value(mb_count_src),
    .o_count(shift_count)
  );

  // sequencer and instruction_reg
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_q <= ext_arith_pkg::ST_IDLE;
      instr_q <= ext_arith_pkg::IR_RESET;
    end else begin
      unique case (state_q)
        ext_arith_pkg::ST_IDLE: begin
          if (own_fetch) begin
            instr_q <= i_cpu.mb[ext_arith_pkg::MB_IR_LO:ext_arith_pkg::MB_IR_HI];
          end
          if (nmi_start) begin
            state_q <= ext_arith_pkg::ST_RUN;
          end
        end
        ext_arith_pkg::ST_RUN: begin
          if (end_fire) begin
            state_q <= ext_arith_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= ext_arith_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // operand registers: bus loads while idle, left shift per step
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      primary_q <= ext_arith_pkg::WORD_ZERO;
      quotient_q <= ext_arith_pkg::WORD_ZERO;
    end else if (shift_fire) begin
      // carry bit is neither shifted in nor kept
      primary_q <= primary_shift;
      quotient_q <= quotient_shift;
    end else if (bus_write && i_wb_adr == ext_arith_pkg::ADR_PRIMARY) begin
      primary_q <= wr_word;
    end else if (bus_write && i_wb_adr == ext_arith_pkg::ADR_QUOTIENT) begin
      quotient_q <= wr_word;
    end
  end

  // arithmetic time pulse divider, runs only during timing
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      at_div_q <= 6'h00;
      at_pulse_q <= 1'b0;
    end else if (running && !end_fire) begin
      at_pulse_q <= (at_div_q == ext_arith_pkg::AT_LAST);
      at_div_q <= (at_div_q == ext_arith_pkg::AT_LAST) ? 6'h00 : at_div_q + 6'h01;
    end else begin
      at_div_q <= 6'h00;
      at_pulse_q <= 1'b0;
    end
  end

  // load strobe stretcher, one strobe per step
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      strobe_cnt_q <= 4'h0;
      cpu_q.load_strobe <= 1'b0;
    end else if (shift_fire) begin
      strobe_cnt_q <= ext_arith_pkg::LOAD_COUNT;
      cpu_q.load_strobe <= 1'b1;
    end else if (strobe_cnt_q > 4'h1) begin
      strobe_cnt_q <= strobe_cnt_q - 4'h1;
    end else begin
      strobe_cnt_q <= 4'h0;
      cpu_q.load_strobe <= 1'b0;
    end
  end

  // processor control outputs
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cpu_q.arith_begin <= 1'b0;
      cpu_q.arith_start_n <= 1'b1;
      cpu_q.pause_set <= 1'b0;
      cpu_q.goto_execute <= 1'b0;
      cpu_q.end_pulse <= 1'b0;
      cpu_q.already_scaled_n <= 1'b0;
    end else begin
      cpu_q.arith_begin <= nmi_start || arith_begin_now;
      cpu_q.arith_start_n <= !nmi_start;
      cpu_q.goto_execute <= scl_go;
      cpu_q.end_pulse <= end_fire;
      cpu_q.already_scaled_n <= scaled;
      if (nmi_start) begin
        cpu_q.pause_set <= 1'b1;
      end else if (end_fire) begin
        cpu_q.pause_set <= 1'b0;
      end
    end
  end

  assign o_cpu = cpu_q;

  // wishbone answer, one wait state, unmapped reads return zero
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= ext_arith_pkg::DATA_ZERO;
    end else begin
      o_wb_ack <= bus_req;
      o_wb_dat <= ext_arith_pkg::DATA_ZERO;
      if (bus_req && !i_wb_we) begin
        unique case (i_wb_adr)
          ext_arith_pkg::ADR_PRIMARY: o_wb_dat[11:0] <= primary_q;
          ext_arith_pkg::ADR_QUOTIENT: o_wb_dat[11:0] <= quotient_q;
          ext_arith_pkg::ADR_STATUS: begin
            o_wb_dat[4:0] <= shift_count;
            o_wb_dat[ext_arith_pkg::STAT_IR_LO +: ext_arith_pkg::IR_W] <= instr_q;
            o_wb_dat[ext_arith_pkg::STAT_BUSY] <= running;
            o_wb_dat[ext_arith_pkg::STAT_SCALED] <= scaled;
            o_wb_dat[ext_arith_pkg::STAT_PAUSE] <= cpu_q.pause_set;
          end
          default: o_wb_dat <= ext_arith_pkg::DATA_ZERO;
        endcase
      end
    end
  end

  // helper: shifts done in the current normalize
  always_ff @(posedge i_clock) begin
    if (i_reset || nmi_fire) begin
      shifts_seen_q <= 6'h00;
    end else if (shift_fire) begin
      shifts_seen_q <= shifts_seen_q + 6'h01;
    end
  end

  // helper: cycles the load strobe has stood high so far
  always_ff @(posedge i_clock) begin
    if (i_reset || !o_cpu.load_strobe) begin
      strobe_len_q <= 4'h0;
    end else begin
      strobe_len_q <= strobe_len_q + 4'h1;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  chk_shift_left_join: assert property (shift_fire |=> primary_q == $past(primary_shift))
    else $error("primary did not take joined left shift");
  chk_zero_fill_low: assert property (shift_fire |=> quotient_q[ext_arith_pkg::WORD_W-1] == 1'b0)
    else $error("quotient bit 11 not zero after shift");
  chk_count_equals_shifts: assert property ($fell(running) |-> shift_count == shifts_seen_q[4:0])
    else $error("shift count differs from shifts done");
  chk_start_and_pause: assert property (nmi_start |=> !o_cpu.arith_start_n && o_cpu.pause_set ##1
                                        o_cpu.arith_start_n && running)
    else $error("normalize start not signalled");
  chk_already_scaled: assert property (nmi_fire && scaled |=> !running && !o_cpu.pause_set && shift_count == 5'h00)
    else $error("scaled operand was shifted");
  chk_strobe_width_ten: assert property ($fell(o_cpu.load_strobe) |-> strobe_len_q == ext_arith_pkg::LOAD_COUNT)
    else $error("load strobe width wrong");
  chk_strobe_not_long: assert property (o_cpu.load_strobe |-> strobe_len_q < ext_arith_pkg::LOAD_COUNT)
    else $error("load strobe stayed high too long");
  chk_step_load_value: assert property (scl_fire |=>
                                        shift_count == ~$past(i_cpu.mb[ext_arith_pkg::MB_SC_LO:ext_arith_pkg::MB_SC_HI]))
    else $error("step count not complement of word tail");
  chk_step_no_start: assert property (scl_fire |=> o_cpu.arith_start_n && !running)
    else $error("step-count load started timing");
  chk_end_resumes: assert property (end_fire |=> o_cpu.end_pulse && !o_cpu.pause_set && !running)
    else $error("end flag did not release pause");
  chk_goto_execute_req: assert property (scl_go |=> o_cpu.goto_execute)
    else $error("goto_execute not requested");
  chk_pulse_spacing: assert property (shift_fire |=> !at_pulse_q [*8])
    else $error("arithmetic pulses too close");
endmodule

// ---- rtl/step_counter.sv ----
// five-bit shift_count register with clear, increment and complement load
`timescale 1ns/10ps
module step_counter (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // controls
  input wire logic i_clear,
  input wire logic i_increment,
  input wire logic i_load,
  input wire logic [0:ext_arith_pkg::SC_W-1] i_load_value,
  // state
  output logic [0:ext_arith_pkg::SC_W-1] o_count
);
  // clear wins, then load, then count up; bit 0 is the high-order bit
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_count <= 5'h00;
    end else if (i_clear) begin
      o_count <= 5'h00;
    end else if (i_load) begin
      o_count <= i_load_value;
    end else if (i_increment) begin
      o_count <= o_count + 5'h01;
    end
  end
endmodule

// ---- verif/cpu_partner.sv ----
// processor-side model: fetch, pause hold, execute and program counter
`timescale 1ns/10ps
module cpu_partner (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // bench control
  input wire logic i_go,
  input wire logic [11:0] i_instr,
  input wire logic [11:0] i_next,
  output logic o_done,
  // unit side
  input wire ext_arith_pkg::cpu_out_t i_eae,
  output ext_arith_pkg::cpu_in_t o_cpu
);
  int pc_q;
  logic exe_q;

  // one instruction: fetch, wait out pause, then optional execute
  task automatic run();
    int n;
    n = 0;
    o_cpu.fetch <= 1'b1;
    o_cpu.operate <= 1'b1;
    o_cpu.mb <= i_instr;
    pc_q <= pc_q + 1;
    @(posedge i_clock);
    o_cpu.tp3 <= 1'b1;
    @(posedge i_clock);
    o_cpu.tp3 <= 1'b0;
    @(posedge i_clock);
    exe_q = i_eae.goto_execute;
    // stays in fetch until the end pulse drops pause
    while (i_eae.pause_set === 1'b1 && n < 2000) begin
      @(posedge i_clock);
      n++;
    end
    o_cpu.tp4 <= 1'b1;
    @(posedge i_clock);
    o_cpu.tp4 <= 1'b0;
    if (exe_q) begin
      o_cpu.fetch <= 1'b0;
      o_cpu.execute <= 1'b1;
      o_cpu.mb <= i_next;
      pc_q <= pc_q + 1;
      @(posedge i_clock);
      o_cpu.tp3 <= 1'b1;
      @(posedge i_clock);
      o_cpu.tp3 <= 1'b0;
      @(posedge i_clock);
    end
    // leave execute; buffer shows a changed word
    o_cpu.execute <= 1'b0;
    o_cpu.fetch <= 1'b0;
    o_cpu.mb <= ~i_instr;
    o_done <= 1'b1;
  endtask

  // waits for a request from the bench
  initial begin
    o_cpu = '0;
    o_done = 1'b0;
    pc_q = 0;
    exe_q = 1'b0;
    forever begin
      @(posedge i_clock);
      o_done <= 1'b0;
      if (i_go === 1'b1 && i_reset === 1'b0) begin
        run();
      end
    end
  end
endmodule

// ---- verif/tb_normalize_and_step_count_load.sv ----
// bench for the normalize and step-count load path
`timescale 1ns/10ps
module tb_normalize_and_step_count_load;
  logic i_clock;
  logic i_reset;
  logic wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat, wb_rdat;
  logic go, done, clr, seen_start, seen_pause, seen_goto, strobe_prev, seen_end, seen_begin;
  logic [11:0] instr, next_w;
  ext_arith_pkg::cpu_in_t cpu_in;
  ext_arith_pkg::cpu_out_t cpu_out;
  int err_count, num_checks, cycles, edges, hi_cycles;

  // 100 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  ext_arith_unit i_dut (
    .i_clock(i_clock), .i_reset(i_reset), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we),
    .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_wdat), .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack),
    .i_cpu(cpu_in), .o_cpu(cpu_out)
  );

  cpu_partner i_cpu_model (
    .i_clock(i_clock), .i_reset(i_reset), .i_go(go), .i_instr(instr), .i_next(next_w),
    .o_done(done), .i_eae(cpu_out), .o_cpu(cpu_in)
  );

  // watches unit outputs during one run
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    strobe_prev <= cpu_out.load_strobe;
    if (clr) begin
      edges <= 0;
      hi_cycles <= 0;
      seen_start <= 1'b0;
      seen_pause <= 1'b0;
      seen_goto <= 1'b0;
      seen_end <= 1'b0;
      seen_begin <= 1'b0;
    end else begin
      if (cpu_out.load_strobe === 1'b1) hi_cycles <= hi_cycles + 1;
      if (cpu_out.load_strobe === 1'b1 && strobe_prev !== 1'b1) edges <= edges + 1;
      if (cpu_out.arith_start_n === 1'b0) seen_start <= 1'b1;
      if (cpu_out.pause_set === 1'b1) seen_pause <= 1'b1;
      if (cpu_out.goto_execute === 1'b1) seen_goto <= 1'b1;
      if (cpu_out.end_pulse === 1'b1) seen_end <= 1'b1;
      if (cpu_out.arith_begin === 1'b1) seen_begin <= 1'b1;
    end
  end

  // cuts a hang short
  always @(posedge i_clock) begin
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; a read compares masked data with wd
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd, input logic [31:0] mask);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= wd;
    do begin
      @(posedge i_clock);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    check({31'h0, wb_ack}, 32'h1);
    if (!we) check(wb_rdat & mask, wd);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge i_clock);
  endtask

  task automatic run_cpu(input logic [11:0] iw, input logic [11:0] nw);
    int n;
    n = 0;
    instr <= iw;
    next_w <= nw;
    go <= 1'b1;
    clr <= 1'b1;
    @(posedge i_clock);
    go <= 1'b0;
    clr <= 1'b0;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge i_clock);
      n++;
    end
    check({31'h0, done}, 32'h1);
    @(posedge i_clock);
  endtask

  // shifts needed until bits 00/01 differ or the rest is zero
  function automatic int shifts(inout logic [23:0] v);
    int n;
    n = 0;
    while (v[23] == v[22] && v[21:0] != 22'h0) begin
      v = v << 1;
      n++;
    end
    return n;
  endfunction

  task automatic test_regs();
    check({31'h0, cpu_out.arith_start_n}, 32'h1);
    check({31'h0, cpu_out.pause_set}, 32'h0);
    wb(1'b0, ext_arith_pkg::ADR_STATUS, 32'h0, 32'h5FF);
    wb(1'b1, ext_arith_pkg::ADR_PRIMARY, 32'hABC, 32'h0);
    wb(1'b0, ext_arith_pkg::ADR_PRIMARY, 32'hABC, 32'hFFF);
    wb(1'b1, ext_arith_pkg::ADR_STATUS, 32'h1F, 32'h0);
    wb(1'b0, ext_arith_pkg::ADR_STATUS, 32'h0, 32'h5FF);
    wb(1'b0, 8'h0C, 32'h0, 32'hFFFF_FFFF);
    $display("test regs done");
  endtask

  task automatic test_already_scaled_n(input logic [11:0] ac, input logic [11:0] mq);
    logic [23:0] v;
    int n;
    v = {ac, mq};
    n = shifts(v);
    wb(1'b1, ext_arith_pkg::ADR_PRIMARY, {20'h0, ac}, 32'h0);
    wb(1'b1, ext_arith_pkg::ADR_QUOTIENT, {20'h0, mq}, 32'h0);
    check({31'h0, cpu_out.already_scaled_n}, 32'(n == 0));
    run_cpu(12'hF09, 12'h000);
    wb(1'b0, ext_arith_pkg::ADR_PRIMARY, {20'h0, v[23:12]}, 32'hFFF);
    wb(1'b0, ext_arith_pkg::ADR_QUOTIENT, {20'h0, v[11:0]}, 32'hFFF);
    wb(1'b0, ext_arith_pkg::ADR_STATUS, 32'(n) | 32'h80, 32'h5FF);
    check(32'(edges), 32'(n));
    check(32'(hi_cycles), 32'(n * ext_arith_pkg::LOAD_CYCLES));
    check({31'h0, seen_start}, 32'(n != 0));
    check({31'h0, seen_pause}, 32'(n != 0));
    check({31'h0, seen_goto}, 32'h0);
    check({31'h0, seen_end}, 32'(n != 0));
    check({31'h0, seen_begin}, 32'(n != 0));
    check({31'h0, cpu_out.already_scaled_n}, 32'h1);
    $display("test already_scaled_n %h %h done", ac, mq);
  endtask

  task automatic test_scl(input logic [11:0] w);
    run_cpu(12'hF03, w);
    wb(1'b0, ext_arith_pkg::ADR_STATUS, {27'h1, ~w[4:0]}, 32'h5FF);
    check({31'h0, seen_goto}, 32'h1);
    check({31'h0, seen_start}, 32'h0);
    check({31'h0, seen_pause}, 32'h0);
    check({31'h0, seen_begin}, 32'h1);
    check({31'h0, seen_end}, 32'h0);
    run_cpu(12'hF02, 12'h000);
    check({31'h0, seen_goto}, 32'h0);
    check({31'h0, seen_begin}, 32'h0);
    wb(1'b0, ext_arith_pkg::ADR_STATUS, {27'h1, ~w[4:0]}, 32'h5FF);
    $display("test scl %h done", w);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    i_reset = 1'b1;
    {wb_cyc, wb_stb, wb_we, go, clr} = 5'h0;
    wb_sel = 4'hF;
    wb_adr = 8'h00;
    wb_wdat = 32'h0;
    instr = 12'h000;
    next_w = 12'h000;
    {err_count, num_checks, cycles, edges, hi_cycles} = {5{32'h0}};
    repeat (20) @(posedge i_clock);
    i_reset <= 1'b0;
    @(posedge i_clock);
    test_regs();
    test_already_scaled_n(12'h400, 12'h000);
    test_already_scaled_n(12'h000, 12'h000);
    test_already_scaled_n(12'h001, 12'h000);
    test_already_scaled_n(12'h000, 12'h001);
    test_already_scaled_n(12'hFFF, 12'hFFF);
    test_already_scaled_n(12'h123, 12'h456);
    test_scl(12'h01F);
    test_scl(12'h015);
    test_scl(12'hFE0);
    test_scl(12'h003);
    wrap_up();
  end
endmodule
